/* inc/owm_params.svh */
`ifndef OWM_PARAMS_SVH
`define OWM_PARAMS_SVH

// ==========================================================================
// clocking and time base
// ==========================================================================
`define OWM_CLK_HZ          40000000
`define OWM_TICK_HZ         1000000
// integer division of the main clock down to the microsecond tick
`define OWM_TICK_DIV        (`OWM_CLK_HZ / `OWM_TICK_HZ)
// below this main clock the sequences lose their tolerance
`define OWM_MIN_CLK_HZ      10000000
// tightest relative timing error allowed, in parts per ten thousand
`define OWM_MAX_ERR_PPTT    645

// ==========================================================================
// sequence times in microseconds (one tick each)
// ==========================================================================
`define OWM_RESET_LOW_US    511
`define OWM_RESET_HIGH_US   512
`define OWM_PRESENCE_US     68
`define OWM_ZERO_LOW_US     100
`define OWM_SLOT_US         117
`define OWM_READ_LOW_US     5
`define OWM_READ_SAMPLE_US  13

// ==========================================================================
// register offsets (byte addresses)
// ==========================================================================
`define OWM_ADR_CTRL        8'h00
`define OWM_ADR_STATUS      8'h04
`define OWM_ADR_INT_STATUS  8'h08
`define OWM_ADR_INT_MASK    8'h0c

// ==========================================================================
// field positions
// ==========================================================================
// control: triggers, self clearing
`define OWM_CTRL_RESET      0
`define OWM_CTRL_ZERO       1
`define OWM_CTRL_ONE        2
// status
`define OWM_STAT_PRESENCE   0
`define OWM_STAT_READ       1
`define OWM_STAT_BUSY       2
// interrupt status and mask: sequence done events
`define OWM_EVT_RESET       0
`define OWM_EVT_ZERO        1
`define OWM_EVT_ONE         2
`define OWM_EVT_W           3

`endif

/* inc/owm_pkg.sv */
package owm_pkg;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_RST_LOW  = 5'b00010,
    ST_RST_HIGH = 5'b00100,
    ST_ZERO     = 5'b01000,
    ST_ONE      = 5'b10000
  } state_type;

endpackage

/* hw/us_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// microsecond time base
// ==========================================================================
module us_tick_gen #(
  parameter int unsigned DIV = 40
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] count;

  // free divider, realigned when a sequence phase starts
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (count == CW'(DIV - 1)) begin
      count  <= '0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule // us_tick_gen

`default_nettype wire

/* hw/one_wire_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
`include "owm_params.svh"

// Summary of operation
// - write-zero slot lasts 117 us, line held low the first 100 us
// - write-zero trigger starts the slot, cleared by hardware when done
// - write-one and read slots share one waveform, starting with low
// - write-one/read trigger launches one slot, cleared when it finishes
// - read value flag loaded with the line level sampled in the slot
// - presence flag is one if a slave answered the reset, else zero
// - reset: 511 us low, 512 us released, presence sampled at 68 us
// - read slot: low 5 us, then released, sampled 13 us after fall
// - every sequence time within 0.0645 relative error of nominal
// - time base is the main clock divided by an integer to 1 MHz
// - main clock must be at least 10 MHz
module one_wire_bus_master #(
  parameter int unsigned TICK_DIV      = `OWM_TICK_DIV,
  parameter int unsigned RESET_LOW_US  = `OWM_RESET_LOW_US,
  parameter int unsigned RESET_HIGH_US = `OWM_RESET_HIGH_US,
  parameter int unsigned SLOT_US       = `OWM_SLOT_US
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // interrupt
  output logic             irq_o,
  // one-wire pad, open drain
  input  wire logic        owire_i,
  output logic             owire_o,
  output logic             owire_oe_n_o
);

  import owm_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  state_type  state;
  state_type  next_state;
  logic [9:0] us_count;
  logic       tick;
  logic       restart;
  logic       phase_end;
  logic       drive_low;
  logic [2:0] line_sync;
  logic       line;
  logic [`OWM_EVT_W-1:0] trig;
  logic       ctrl_wr;
  logic       presence_flag;
  logic       read_value_flag;
  logic [`OWM_EVT_W-1:0] int_status;
  logic [`OWM_EVT_W-1:0] int_mask;
  logic [`OWM_EVT_W-1:0] done_evt;
  logic       bus_req;
  logic       bus_wr;
  logic       sel_low;
  logic [31:0] next_dat;

  // ==========================================================================
  // time base
  // ==========================================================================
  // integer division of 40 MHz by 40 gives exactly 1 us, no drift
  us_tick_gen #(
    .DIV       (TICK_DIV)
  ) u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (restart),
    .tick_o    (tick)
  );

  // ==========================================================================
  // pad input synchroniser
  // ==========================================================================
  // three stages; the level moves only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_sync <= 3'h7;
    end else begin
      line_sync <= {line_sync[1:0], owire_i};
    end
  end

  // filtered line level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line <= 1'b1;
    end else if (line_sync[1] == line_sync[2]) begin
      line <= line_sync[2];
    end
  end

  // ==========================================================================
  // wishbone slave
  // ==========================================================================
  assign bus_req = cyc_i && stb_i;
  // writes land on the edge where ack is seen high
  assign bus_wr  = bus_req && ack_o && we_i;
  assign sel_low = sel_i[0];

  // one wait state, ack dropped the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req && !ack_o;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      `OWM_ADR_CTRL: begin
        next_dat[`OWM_EVT_W-1:0] = trig;
      end
      `OWM_ADR_STATUS: begin
        next_dat[`OWM_STAT_PRESENCE] = presence_flag;
        next_dat[`OWM_STAT_READ]     = read_value_flag;
        next_dat[`OWM_STAT_BUSY]     = (state != ST_IDLE);
      end
      `OWM_ADR_INT_STATUS: begin
        next_dat[`OWM_EVT_W-1:0] = int_status;
      end
      `OWM_ADR_INT_MASK: begin
        next_dat[`OWM_EVT_W-1:0] = int_mask;
      end
      default: begin
        next_dat = 32'h0000_0000;
      end
    endcase
  end

  // read data registered in the cycle before ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !ack_o) begin
      dat_o <= next_dat;
    end
  end

  // ==========================================================================
  // trigger bits
  // ==========================================================================
  // a written one sets a trigger, hardware clears it when its sequence
  // ends, a new set wins; control bits sit at the done event positions
  assign ctrl_wr = bus_wr && sel_low && adr_i == `OWM_ADR_CTRL;
  for (genvar g = 0; g < `OWM_EVT_W; g++) begin : g_trig
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        trig[g] <= 1'b0;
      end else if (ctrl_wr && dat_i[g]) begin
        trig[g] <= 1'b1;
      end else if (done_evt[g]) begin
        trig[g] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // sequencer
  // ==========================================================================
  // last tick of the running phase
  always_comb begin
    phase_end = 1'b0;
    unique case (state)
      ST_RST_LOW:  phase_end = (us_count == 10'(RESET_LOW_US - 1));
      ST_RST_HIGH: phase_end = (us_count == 10'(RESET_HIGH_US - 1));
      ST_ZERO:     phase_end = (us_count == 10'(SLOT_US - 1));
      ST_ONE:      phase_end = (us_count == 10'(SLOT_US - 1));
      ST_IDLE:     phase_end = 1'b0;
    endcase
  end

  // next state; reset first, then write zero, then write one/read
  always_comb begin
    next_state = state;
    done_evt   = '0;
    restart    = 1'b0;
    unique case (state)
      ST_IDLE: begin
        restart = 1'b1;
        if (trig[`OWM_CTRL_RESET]) begin
          next_state = ST_RST_LOW;
        end else if (trig[`OWM_CTRL_ZERO]) begin
          next_state = ST_ZERO;
        end else if (trig[`OWM_CTRL_ONE]) begin
          next_state = ST_ONE;
        end
      end
      ST_RST_LOW: begin
        if (tick && phase_end) begin
          next_state = ST_RST_HIGH;
          restart    = 1'b1;
        end
      end
      ST_RST_HIGH: begin
        if (tick && phase_end) begin
          next_state = ST_IDLE;
          done_evt[`OWM_EVT_RESET] = 1'b1;
        end
      end
      ST_ZERO: begin
        if (tick && phase_end) begin
          next_state = ST_IDLE;
          done_evt[`OWM_EVT_ZERO] = 1'b1;
        end
      end
      ST_ONE: begin
        if (tick && phase_end) begin
          next_state = ST_IDLE;
          done_evt[`OWM_EVT_ONE] = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // microseconds elapsed in the running phase
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      us_count <= 10'h000;
    end else if (tick) begin
      us_count <= us_count + 10'h001;
    end
  end

  // ==========================================================================
  // line drive
  // ==========================================================================
  // low from the phase start until the low time has elapsed
  always_comb begin
    drive_low = 1'b0;
    unique case (next_state)
      ST_RST_LOW:  drive_low = 1'b1;
      ST_ZERO:     drive_low = (us_count < 10'(`OWM_ZERO_LOW_US)) &&
                               !(tick && us_count ==
                                 10'(`OWM_ZERO_LOW_US - 1));
      ST_ONE:      drive_low = (us_count < 10'(`OWM_READ_LOW_US)) &&
                               !(tick && us_count ==
                                 10'(`OWM_READ_LOW_US - 1));
      ST_RST_HIGH: drive_low = 1'b0;
      ST_IDLE:     drive_low = 1'b0;
    endcase
  end

  // open drain: data held at zero, enable active low pulls the line
  assign owire_o = 1'b0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      owire_oe_n_o <= 1'b1;
    end else begin
      owire_oe_n_o <= !drive_low;
    end
  end

  // ==========================================================================
  // sampled results
  // ==========================================================================
  // presence: a low line 68 us into the release means a slave answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presence_flag <= 1'b0;
    end else if (state == ST_RST_HIGH && tick &&
                 us_count == 10'(`OWM_PRESENCE_US - 1)) begin
      presence_flag <= !line;
    end
  end

  // read value: the slave may hold the line low to answer a zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_value_flag <= 1'b0;
    end else if (state == ST_ONE && tick &&
                 us_count == 10'(`OWM_READ_SAMPLE_US - 1)) begin
      read_value_flag <= line;
    end
  end

  // ==========================================================================
  // interrupts
  // ==========================================================================
  // sticky done events, write one to clear, a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= '0;
    end else begin
      if (bus_wr && sel_low && adr_i == `OWM_ADR_INT_STATUS) begin
        int_status <= (int_status & ~dat_i[`OWM_EVT_W-1:0]) | done_evt;
      end else begin
        int_status <= int_status | done_evt;
      end
    end
  end

  // mask, one enables the event onto the interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask <= '0;
    end else if (bus_wr && sel_low && adr_i == `OWM_ADR_INT_MASK) begin
      int_mask <= dat_i[`OWM_EVT_W-1:0];
    end
  end

  // level interrupt while any unmasked event is pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_status & int_mask);
    end
  end

endmodule // one_wire_bus_master

`default_nettype wire

/* sim/owm_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// port checker of the one-wire master
// ==========================================================================
module owm_properties #(
  parameter int unsigned TICK_DIV     = 40,
  parameter int unsigned RESET_LOW_US = 511
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        owire_i,
  input wire logic        owire_o,
  input wire logic        owire_oe_n_o
);
  localparam int RL = RESET_LOW_US * TICK_DIV;
  localparam int ZL = 100 * TICK_DIV;
  localparam int WL = 5 * TICK_DIV;
  int low_cnt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // length of the current low pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || owire_oe_n_o) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end

  property p_drive_zero; owire_o == 1'b0; endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("pad data not zero");
  property p_low_width;
    $rose(owire_oe_n_o) |-> (low_cnt inside
      {[WL-2:WL+2], [ZL-2:ZL+2], [RL-2:RL+2]});
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("low pulse of wrong length");
  property p_low_max; low_cnt <= RL + 2; endproperty
  a_low_max: assert property (p_low_max)
    else $error("low pulse too long");
  property p_read_release;
    $rose(owire_oe_n_o) && low_cnt < WL + 3 |-> owire_oe_n_o [*8];
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("line not released after short low");
  property p_ack_wait; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_wait: assert property (p_ack_wait)
    else $error("ack not one cycle after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hold; !$rose(ack_o) |-> $stable(dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved outside an answer");
  property p_reset_idle;
    disable iff (1'b0) rst_i |=> owire_oe_n_o && !ack_o && !irq_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle in reset");

  c_reset: cover property ($rose(owire_oe_n_o) && low_cnt > RL - 3);
  c_zero: cover property (low_cnt == ZL);
  c_irq: cover property ($rose(irq_o));
endmodule // owm_properties

`default_nettype wire

/* sim/ow_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// behavioural one-wire slave
// ==========================================================================
module ow_slave_model (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic present_i,
  input  wire logic bit_i,
  output logic      pull_o
);
  int   low_cnt  = 0;
  int   act_cnt  = 0;
  int   pull_len = 0;
  logic last     = 1'b1;

  // pull low in the last pull_len counts of the active window, the whole of it for a read zero
  assign pull_o = (act_cnt != 0) && (act_cnt <= pull_len);

  // watch the line, answer a reset or a read zero
  always @(posedge clk_i) begin
    last <= line_i;
    low_cnt <= line_i ? 0 : low_cnt + 1;
    if (act_cnt != 0) act_cnt <= act_cnt - 1;
    // reset detected above 125 us low: presence from 15 to 75 us
    if (line_i && !last && low_cnt > 5000 && present_i) begin
      act_cnt <= 3000;
      pull_len <= 2400;
    end else if (!line_i && last && act_cnt == 0 && !bit_i) begin
      act_cnt <= 600;
      pull_len <= 600;
    end
  end
endmodule // ow_slave_model

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// bench of the one-wire master
// ==========================================================================
module tb;
  typedef struct { logic chk; logic [31:0] val; } note_type;
  localparam int unsigned RLOW = 150;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_o;
  logic        ack_o, irq_o, ow_o, ow_oe_n, line, pull;
  logic        present = 1'b1, rbit = 1'b1, b;
  note_type    notes[$];
  note_type    nt;
  int          bad_count = 0, checked = 0, cycles = 0;

  // open drain line with pull-up
  assign line = !ow_oe_n ? ow_o : !pull;

  one_wire_bus_master #(.RESET_LOW_US(RLOW), .RESET_HIGH_US(80)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o),
    .ack_o(ack_o), .irq_o(irq_o), .owire_i(line), .owire_o(ow_o),
    .owire_oe_n_o(ow_oe_n));
  ow_slave_model slave (.clk_i(clk_i), .line_i(line),
    .present_i(present), .bit_i(rbit), .pull_o(pull));

  always #12.5 clk_i = ~clk_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // one classic cycle; d is write data or expected read data
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic c);
    int n;
    n = 0;
    notes.push_back('{c, d});
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) check_val(32'hffffffff, 32'h0);
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_o !== lvl && n < 12000) begin
      @(posedge clk_i);
      n++;
    end
    check_val({31'h0, irq_o}, {31'h0, lvl});
  endtask

  // trigger one sequence, then see triggers and events cleared
  task automatic run_seq(input logic [31:0] v);
    wb(1'b1, 8'h00, v, 1'b0);
    wait_irq(1'b1);
    wb(1'b0, 8'h00, 32'h0, 1'b1);
    wb(1'b0, 8'h08, v, 1'b1);
    wb(1'b1, 8'h08, v, 1'b0);
    wait_irq(1'b0);
  endtask

  // result watcher: oldest note against each answer
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.chk) check_val(dat_o, nt.val);
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      $display("mismatch at %0t: run timed out", $time);
      summarize();
    end
  end

  initial begin
    void'($urandom(50));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // register reset values and an unmapped place
    wb(1'b0, 8'h00, 32'h0, 1'b1);
    wb(1'b0, 8'h04, 32'h0, 1'b1);
    wb(1'b0, 8'h08, 32'h0, 1'b1);
    wb(1'b0, 8'h0c, 32'h0, 1'b1);
    wb(1'b1, 8'h10, $urandom, 1'b0);
    wb(1'b0, 8'h10, 32'h0, 1'b1);
    wb(1'b1, 8'h0c, 32'h7, 1'b0);
    wb(1'b0, 8'h0c, 32'h7, 1'b1);
    $display("test registers done");
    // reset sequence with and without a slave
    for (int p = 1; p >= 0; p--) begin
      present <= p[0];
      run_seq(32'h1);
      wb(1'b0, 8'h04, {31'h0, p[0]}, 1'b1);
    end
    $display("test presence done");
    run_seq(32'h2);
    wb(1'b0, 8'h04, 32'h0, 1'b1);
    $display("test write zero done");
    // random read bits
    for (int i = 0; i < 4; i++) begin
      b = 1'($urandom);
      rbit <= b;
      run_seq(32'h4);
      wb(1'b0, 8'h04, {30'h0, b, 1'b0}, 1'b1);
    end
    $display("test read slots done");
    // masked event, then unmasked
    rbit <= 1'b1;
    wb(1'b1, 8'h0c, 32'h0, 1'b0);
    wb(1'b1, 8'h00, 32'h4, 1'b0);
    repeat (5000) @(posedge clk_i);
    check_val({31'h0, irq_o}, 32'h0);
    wb(1'b0, 8'h08, 32'h4, 1'b1);
    wb(1'b0, 8'h04, 32'h2, 1'b1);
    wb(1'b1, 8'h0c, 32'h4, 1'b0);
    wait_irq(1'b1);
    wb(1'b1, 8'h08, 32'h4, 1'b0);
    wait_irq(1'b0);
    wb(1'b0, 8'h08, 32'h0, 1'b1);
    $display("test interrupt mask done");
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule // tb

bind one_wire_bus_master owm_properties #(
  .TICK_DIV(TICK_DIV), .RESET_LOW_US(RESET_LOW_US)) props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .owire_i(owire_i),
  .owire_o(owire_o), .owire_oe_n_o(owire_oe_n_o));

`default_nettype wire
